// *** verilog/cts_pkg.sv ***
// constants, register map and state type of the capacitive touch scanner
package cts_pkg;

    // ========================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CH3_HI = 8'hD9;
    localparam logic [7:0] IDX_CH4_LO = 8'hDA;
    localparam logic [7:0] IDX_CH4_HI = 8'hDB;
    localparam logic [7:0] IDX_REF_LO = 8'hDC;
    localparam logic [7:0] IDX_REF_HI = 8'hDD;
    localparam logic [7:0] IDX_CLK_SRC = 8'hDE;
    localparam logic [7:0] IDX_ANALOG = 8'hDF;
    localparam logic [7:0] IDX_CH0_LO = 8'hE1;
    localparam logic [7:0] IDX_CH0_HI = 8'hE2;
    localparam logic [7:0] IDX_CH1_LO = 8'hE3;
    localparam logic [7:0] IDX_CH1_HI = 8'hE4;
    localparam logic [7:0] IDX_CH2_LO = 8'hE5;
    localparam logic [7:0] IDX_CH2_HI = 8'hE6;
    localparam logic [7:0] IDX_CH3_LO = 8'hE7;
    localparam logic [7:0] IDX_CONTROL = 8'hF8;
    localparam logic [7:0] IDX_DIV_DIS = 8'hF9;
    localparam logic [7:0] IDX_INTERVAL = 8'hFA;
    localparam logic [7:0] IDX_DONE = 8'hFB;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hFC;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'hFD;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'hFE;

    // ========================================================
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h04;
    localparam logic [7:0] ANALOG_RST = 8'h00;
    localparam logic [7:0] DIV_DIS_RST = 8'h1F;
    localparam logic [5:0] IRQ_EN_RST = 6'h3F;

    // ========================================================
    // field positions
    localparam int CTL_START = 7;
    localparam int CTL_IE = 6;
    localparam int CTL_MODE = 5;
    localparam int CTL_HOP = 4;
    localparam int CTL_REF = 3;
    localparam int DIV_MSB = 7;
    localparam int DIV_LSB = 5;
    localparam int TMS_MSB = 4;

    // ========================================================
    // idle channel drive codes, prescaler and channel count
    localparam logic [1:0] IDLE_FLOAT = 2'h0;
    localparam logic [1:0] IDLE_LOW = 2'h1;
    localparam logic [1:0] IDLE_COMP = 2'h2;
    localparam logic [1:0] HS_PRESCALE_LAST = 2'h3;
    localparam int NUM_CH = 6;
    localparam logic [2:0] NO_CH = 3'h6;

    typedef enum logic [1:0] {
        S_IDLE,
        S_DISCH,
        S_CHARGE
    } cts_state_e;

endpackage

// *** verilog/cts_top.sv ***
// capacitive touch scanner: apb registers, scan sequencer, pin drive
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps

// Functional notes
// - start by bit in mode 0, timer in 1
// - on completion clear start, flag, store result
// - hopping steps divider 1,2,3,4 per charge cycle
// - hopping ignores programmed touch clock divider
// - idle channels float, low, or compensation drive
// - two bits select amplifier output level
// - sample clock: fast osc over four, slow osc
// - touch clock divided by field plus one
// - discharge lasts setting times 128 touch periods, one period if setting is zero
// - timer fires every (interval+1)*128 slow periods
// - six done flags, software writes one clears
// - interrupt when flag set and enable bit
module cts_top #(
    parameter int UNIT = 128,
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_speed_osc,
    input wire logic high_speed_osc,
    input wire logic [4:0] channel_enable,
    input wire logic comparator_in,
    output logic [5:0] electrode_out,
    output logic [5:0] electrode_oe,
    output logic modcap_discharge,
    output logic touch_irq,
    output logic [2:0] comparator_threshold_select,
    output logic [1:0] amp_output_level,
    output logic [1:0] internal_vref_level,
    output logic charge_supply_select,
    output logic reference_source_select
);

    // ========================================================
    // helpers
    function automatic logic [7:0] pick(input logic [15:0] v,
                                        input logic hi);
        pick = hi ? v[15:8] : v[7:0];
    endfunction

    // first enabled channel at or above start, NO_CH if none
    function automatic logic [2:0] next_ch(input logic [5:0] act,
                                           input logic [2:0] from);
        next_ch = cts_pkg::NO_CH;
        for (int i = cts_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (act[i] && (3'(i) >= from)) begin
                next_ch = 3'(i);
            end
        end
    endfunction

    logic [7:0] touch_control;
    logic [7:0] touch_analog_config;
    logic touch_clock_source;
    logic [7:0] touch_divider_discharge;
    logic [7:0] touch_scan_interval;
    logic [5:0] channel_done_flags;
    logic [5:0] irq_enable;
    logic [15:0] result [cts_pkg::NUM_CH];
    cts_pkg::cts_state_e state;
    logic [2:0] ch_idx;
    logic [15:0] count;
    logic [15:0] dis_cnt;
    logic [15:0] tmr_cnt;
    logic [2:0] div_cnt;
    logic [1:0] hop_step;
    logic [1:0] hs_pre;
    logic phase;
    logic ls_q;
    logic hs_q;

    // ========================================================
    // apb decode
    logic [7:0] idx;
    logic hit;
    logic [7:0] rd_byte;
    logic acc;
    logic wr;
    assign idx = paddr[9:2];
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;

    // read mux; result bytes are read only and change only on store
    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            cts_pkg::IDX_CH0_LO: rd_byte = pick(result[0], 1'b0);
            cts_pkg::IDX_CH0_HI: rd_byte = pick(result[0], 1'b1);
            cts_pkg::IDX_CH1_LO: rd_byte = pick(result[1], 1'b0);
            cts_pkg::IDX_CH1_HI: rd_byte = pick(result[1], 1'b1);
            cts_pkg::IDX_CH2_LO: rd_byte = pick(result[2], 1'b0);
            cts_pkg::IDX_CH2_HI: rd_byte = pick(result[2], 1'b1);
            cts_pkg::IDX_CH3_LO: rd_byte = pick(result[3], 1'b0);
            cts_pkg::IDX_CH3_HI: rd_byte = pick(result[3], 1'b1);
            cts_pkg::IDX_CH4_LO: rd_byte = pick(result[4], 1'b0);
            cts_pkg::IDX_CH4_HI: rd_byte = pick(result[4], 1'b1);
            cts_pkg::IDX_REF_LO: rd_byte = pick(result[5], 1'b0);
            cts_pkg::IDX_REF_HI: rd_byte = pick(result[5], 1'b1);
            cts_pkg::IDX_CLK_SRC: rd_byte = {7'h00, touch_clock_source};
            cts_pkg::IDX_ANALOG: rd_byte = touch_analog_config;
            cts_pkg::IDX_CONTROL: rd_byte = touch_control;
            cts_pkg::IDX_DIV_DIS: rd_byte = touch_divider_discharge;
            cts_pkg::IDX_INTERVAL: rd_byte = touch_scan_interval;
            cts_pkg::IDX_DONE: rd_byte = {2'h0, channel_done_flags};
            cts_pkg::IDX_IRQ_STATUS: rd_byte = {2'h0, channel_done_flags};
            cts_pkg::IDX_IRQ_CLEAR: rd_byte = 8'h00;
            cts_pkg::IDX_IRQ_ENABLE: rd_byte = {2'h0, irq_enable};
            default: hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:10] != '0) begin
            hit = 1'b0;
        end
    end

    // no wait state: answer lands in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~hit;
            if (psel && !penable) begin
                prdata <= {24'h00_0000, hit ? rd_byte : 8'h00};
            end
        end
    end

    // ========================================================
    // oscillator edges and touch clock
    logic ls_rise;
    logic hs_tick;
    logic tclk_tick;
    logic [2:0] div_sel;
    logic charge_tick;
    logic hop_on;
    assign ls_rise = low_speed_osc & ~ls_q;
    assign hs_tick = high_speed_osc & ~hs_q &
                     (hs_pre == cts_pkg::HS_PRESCALE_LAST);
    assign tclk_tick = touch_clock_source ? ls_rise : hs_tick;
    assign hop_on = touch_control[cts_pkg::CTL_HOP];
    // hopping overrides the programmed divider entirely
    assign div_sel = hop_on ? {1'b0, hop_step}
        : touch_divider_discharge[cts_pkg::DIV_MSB:cts_pkg::DIV_LSB];
    assign charge_tick = tclk_tick && (div_cnt == div_sel);

    // edge history and fast oscillator prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_q <= 1'b0;
            hs_q <= 1'b0;
            hs_pre <= 2'h0;
        end else begin
            ls_q <= low_speed_osc;
            hs_q <= high_speed_osc;
            if (high_speed_osc && !hs_q) begin
                hs_pre <= hs_pre + 2'h1;
            end
        end
    end

    // divider restarts each scan so the first period is full length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 3'h0;
        end else if (state == cts_pkg::S_IDLE || charge_tick) begin
            div_cnt <= 3'h0;
        end else if (tclk_tick) begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    // ========================================================
    // interval timer, runs only in timer start mode
    logic [15:0] tmr_target;
    logic timer_fire;
    logic mode_timer;
    assign mode_timer = touch_control[cts_pkg::CTL_MODE];
    assign tmr_target = 16'((16'(touch_scan_interval) + 16'h1)
                            * 16'(UNIT));
    assign timer_fire = mode_timer && ls_rise &&
                        (tmr_cnt == tmr_target - 16'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_cnt <= 16'h0000;
        end else if (!mode_timer || timer_fire) begin
            tmr_cnt <= 16'h0000;
        end else if (ls_rise) begin
            tmr_cnt <= tmr_cnt + 16'h1;
        end
    end

    // ========================================================
    // scan sequencer
    logic [5:0] act;
    logic go;
    logic [15:0] dis_target;
    logic ch_done;
    logic scan_end;
    logic [5:0] done_set;
    logic [2:0] first_ch;
    logic [2:0] follow_ch;
    logic cycle_end;
    assign act = {touch_control[cts_pkg::CTL_REF], channel_enable};
    // a timer tick during a scan is dropped, not queued
    assign go = (state == cts_pkg::S_IDLE) && (mode_timer ? timer_fire
                : touch_control[cts_pkg::CTL_START]);
    // a zero setting ends the discharge phase after one touch period
    assign dis_target = 16'(16'(touch_divider_discharge
                        [cts_pkg::TMS_MSB:0]) * 16'(UNIT));
    assign cycle_end = charge_tick && phase;
    assign ch_done = (state == cts_pkg::S_CHARGE) &&
                     (comparator_in || count == 16'hFFFF);
    assign first_ch = next_ch(act, 3'h0);
    assign follow_ch = next_ch(act, ch_idx + 3'h1);
    assign scan_end = (go && first_ch == cts_pkg::NO_CH) ||
                      (ch_done && follow_ch == cts_pkg::NO_CH);
    assign done_set = ch_done ? 6'(6'h01 << ch_idx) : 6'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= cts_pkg::S_IDLE;
            ch_idx <= 3'h0;
            dis_cnt <= 16'h0000;
            count <= 16'h0000;
            phase <= 1'b0;
        end else begin
            unique case (state)
                cts_pkg::S_IDLE: begin
                    if (go && first_ch != cts_pkg::NO_CH) begin
                        state <= cts_pkg::S_DISCH;
                        ch_idx <= first_ch;
                        dis_cnt <= 16'h0000;
                    end
                end
                cts_pkg::S_DISCH: begin
                    if (charge_tick) begin
                        dis_cnt <= dis_cnt + 16'h1;
                        if (dis_cnt + 16'h1 >= dis_target) begin
                            state <= cts_pkg::S_CHARGE;
                            count <= 16'h0000;
                            phase <= 1'b0;
                        end
                    end
                end
                cts_pkg::S_CHARGE: begin
                    if (ch_done) begin
                        phase <= 1'b0;
                        dis_cnt <= 16'h0000;
                        ch_idx <= follow_ch;
                        state <= (follow_ch == cts_pkg::NO_CH) ?
                                 cts_pkg::S_IDLE : cts_pkg::S_DISCH;
                    end else if (charge_tick) begin
                        phase <= ~phase;
                        if (phase) begin
                            count <= count + 16'h1;
                        end
                    end
                end
            endcase
        end
    end

    // hop step advances once per whole charge cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hop_step <= 2'h0;
        end else if (!hop_on || state == cts_pkg::S_IDLE) begin
            hop_step <= 2'h0;
        end else if (cycle_end && state == cts_pkg::S_CHARGE) begin
            hop_step <= hop_step + 2'h1;
        end
    end

    // results overwrite only when their channel completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < cts_pkg::NUM_CH; i++) begin
                result[i] <= 16'h0000;
            end
        end else if (ch_done) begin
            result[ch_idx] <= count;
        end
    end

    // ========================================================
    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            touch_control <= cts_pkg::CONTROL_RST;
            touch_analog_config <= cts_pkg::ANALOG_RST;
            touch_clock_source <= 1'b0;
            touch_divider_discharge <= cts_pkg::DIV_DIS_RST;
            touch_scan_interval <= 8'h00;
            irq_enable <= cts_pkg::IRQ_EN_RST;
        end else begin
            if (scan_end) begin
                touch_control[cts_pkg::CTL_START] <= 1'b0;
            end
            // a software write of the start bit wins over the clear
            if (wr && idx == cts_pkg::IDX_CONTROL) begin
                touch_control <= pwdata[7:0];
            end
            if (wr && idx == cts_pkg::IDX_ANALOG) begin
                touch_analog_config <= pwdata[7:0];
            end
            if (wr && idx == cts_pkg::IDX_CLK_SRC) begin
                touch_clock_source <= pwdata[0];
            end
            if (wr && idx == cts_pkg::IDX_DIV_DIS) begin
                touch_divider_discharge <= pwdata[7:0];
            end
            if (wr && idx == cts_pkg::IDX_INTERVAL) begin
                touch_scan_interval <= pwdata[7:0];
            end
            if (wr && idx == cts_pkg::IDX_IRQ_ENABLE) begin
                irq_enable <= pwdata[5:0];
            end
        end
    end

    // done flags: write one clears, a same-cycle set wins
    logic [5:0] clr;
    logic [5:0] next_flags;
    assign clr = (wr && (idx == cts_pkg::IDX_DONE ||
                  idx == cts_pkg::IDX_IRQ_CLEAR)) ? pwdata[5:0] : 6'h00;
    assign next_flags = (channel_done_flags & ~clr) | done_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_done_flags <= 6'h00;
            touch_irq <= 1'b0;
        end else begin
            channel_done_flags <= next_flags;
            touch_irq <= touch_control[cts_pkg::CTL_IE] &
                         (|(next_flags & irq_enable));
        end
    end

    // ========================================================
    // electrode and capacitor drive
    logic [1:0] idle_drive;
    logic busy;
    assign idle_drive = touch_analog_config[7:6];
    assign busy = (state != cts_pkg::S_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            electrode_out <= 6'h00;
            electrode_oe <= 6'h00;
            modcap_discharge <= 1'b0;
        end else begin
            modcap_discharge <= (state == cts_pkg::S_DISCH);
            for (int i = 0; i < cts_pkg::NUM_CH; i++) begin
                if (busy && 3'(i) == ch_idx) begin
                    electrode_oe[i] <= 1'b1;
                    electrode_out[i] <= (state == cts_pkg::S_CHARGE) & phase;
                end else begin
                    unique case (idle_drive)
                        cts_pkg::IDLE_LOW: begin
                            electrode_oe[i] <= 1'b1;
                            electrode_out[i] <= 1'b0;
                        end
                        cts_pkg::IDLE_COMP: begin
                            electrode_oe[i] <= 1'b1;
                            electrode_out[i] <=
                                (state == cts_pkg::S_CHARGE) & phase;
                        end
                        default: begin
                            electrode_oe[i] <= 1'b0;
                            electrode_out[i] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // analog settings come straight off register bits
    assign amp_output_level = touch_analog_config[5:4];
    assign internal_vref_level = touch_analog_config[3:2];
    assign charge_supply_select = touch_analog_config[1];
    assign reference_source_select = touch_analog_config[0];
    assign comparator_threshold_select = touch_control[2:0];

    // ========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_bad_setup;
        psel && !penable && !hit;
    endsequence

    a_apb_ready_once: assert property (apb_setup |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    a_apb_bad_addr: assert property (apb_bad_setup |=> pslverr && pready)
        else $error("unmapped address not flagged");
    a_flag_on_done: assert property (ch_done |=>
        channel_done_flags[$past(ch_idx)])
        else $error("done flag not set on completion");
    a_result_stored: assert property (ch_done |=>
        result[$past(ch_idx)] == $past(count))
        else $error("result not stored");
    a_flag_w1c_clear: assert property ((|(clr & ~done_set)) |=>
        ((channel_done_flags & $past(clr & ~done_set)) == 6'h00))
        else $error("write one did not clear flag");
    a_irq_level_tie: assert property (##1 touch_irq ==
        ($past(touch_control[cts_pkg::CTL_IE]) &&
         |(channel_done_flags & $past(irq_enable))))
        else $error("interrupt does not match flags");
    a_start_cleared: assert property (scan_end &&
        !(wr && idx == cts_pkg::IDX_CONTROL) |=>
        !touch_control[cts_pkg::CTL_START])
        else $error("start bit not cleared at scan end");
    a_hop_off_step: assert property (!hop_on |=> hop_step == 2'h0
        || hop_on)
        else $error("hop step moved with hopping off");
    a_timer_only_go: assert property (
        (state == cts_pkg::S_IDLE) &&
        !(mode_timer ? timer_fire : touch_control[cts_pkg::CTL_START])
        |=> state == cts_pkg::S_IDLE)
        else $error("scan started without its trigger");
    a_disch_length: assert property ((state == cts_pkg::S_DISCH) &&
        $past(state) == cts_pkg::S_CHARGE |-> dis_cnt == 16'h0000)
        else $error("discharge count not restarted");
    a_idle_low_drive: assert property (!busy &&
        idle_drive == cts_pkg::IDLE_LOW |=> electrode_oe != 6'h00
        || $past(idle_drive) != cts_pkg::IDLE_LOW)
        else $error("idle channels not driven low");

endmodule

// *** sim/cts_electrode_model.sv ***
// behavioural electrodes, modulation cap and comparator of the scanner
`timescale 1ns/10ps
module cts_electrode_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] electrode_out,
    input wire logic [5:0] electrode_oe,
    input wire logic modcap_discharge,
    input wire logic [15:0] target,
    output logic comparator_in
);
    logic [5:0] prev;
    logic [15:0] cycles;
    // ========================================================
    // charge build-up
    // a falling edge on a driven pin closes one charge cycle; the count
    // is dropped whenever the cap discharges, like the real node
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 6'h00;
            cycles <= 16'h0000;
        end else begin
            prev <= electrode_out;
            if (modcap_discharge) begin
                cycles <= 16'h0000;
            end else if (|(prev & ~electrode_out & electrode_oe)) begin
                cycles <= cycles + 16'h0001;
            end
        end
    end
    // comparator trips once the programmed charge has piled up
    assign comparator_in = (cycles >= target) && !modcap_discharge;
endmodule

// *** sim/capacitive_touch_scanner_test.sv ***
// self-checking bench for the capacitive touch scanner
`timescale 1ns/10ps
module capacitive_touch_scanner_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic hs = 0, ls = 0, pready, pslverr, cmp, dis, irq, sup, rsrc, e;
    logic [4:0] ch_en = 0;
    logic [15:0] target = 16'h0005;
    logic [5:0] eo, eoe;
    logic [2:0] thr;
    logic [1:0] amp, vref;
    logic [7:0] v;
    int mismatches = 0, num_checks = 0, ocnt = 0;
    logic [7:0] ri[6] = '{8'hE1, 8'hDD, 8'hDE, 8'hDF, 8'hF9, 8'hFA};
    logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h00};
    logic [7:0] sdd[3] = '{8'h01, 8'hE1, 8'hE1};
    logic [7:0] sct[3] = '{8'hC0, 8'hC0, 8'hD0};
    // ========================================================
    // clock and oscillators; slow osc far below the fast one
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        hs <= ~hs;
        ocnt <= ocnt + 1;
        if (ocnt % 10 == 9) ls <= ~ls;
    end
    // UNIT shortened so scans stay short
    cts_top #(.UNIT(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_speed_osc(ls), .high_speed_osc(hs),
        .channel_enable(ch_en), .comparator_in(cmp), .electrode_out(eo),
        .electrode_oe(eoe), .modcap_discharge(dis), .touch_irq(irq),
        .comparator_threshold_select(thr), .amp_output_level(amp),
        .internal_vref_level(vref), .charge_supply_select(sup),
        .reference_source_select(rsrc));
    cts_electrode_model pad (.pclk(pclk), .presetn(presetn),
        .electrode_out(eo), .electrode_oe(eoe), .modcap_discharge(dis),
        .target(target), .comparator_in(cmp));
    // ========================================================
    // tasks
    task automatic chk(input string s, input logic [7:0] x,
                       input logic [7:0] g);
        num_checks++;
        if (g !== x) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", s, x, g);
        end
    endtask
    // one apb transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] i,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // a slave that never answers counts against the run
        if (pready !== 1'b1) mismatches++;
        v = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input string s, input logic [7:0] i,
                         input logic [7:0] x);
        apb(1'b0, i, 8'h00);
        chk(s, x, v);
    endtask
    task automatic poll(input logic [7:0] i, input logic [7:0] m,
                        input logic [7:0] w);
        int n;
        n = 0;
        do begin
            apb(1'b0, i, 8'h00);
            n++;
        end while ((v & m) !== w && n < 3000);
        chk("poll", w, v & m);
    endtask
    task automatic scan(input logic [7:0] dd, input logic [7:0] ct,
                        input logic [7:0] fl);
        apb(1'b1, cts_pkg::IDX_DIV_DIS, dd);
        apb(1'b1, cts_pkg::IDX_CONTROL, ct);
        poll(cts_pkg::IDX_CONTROL, 8'h80, 8'h00);
        rdchk("flags", cts_pkg::IDX_DONE, fl);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ========================================================
    // watchdog, well past the longest scan sequence
    initial begin
        #300000;
        mismatches++;
        end_sim;
    end
    // ========================================================
    // tests
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk("threshold", 8'h04, {5'h0, thr});
        rdchk("control", cts_pkg::IDX_CONTROL, 8'h04);
        for (int i = 0; i < 6; i++) rdchk("reset", ri[i], rv[i]);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, cts_pkg::IDX_ANALOG, {2'b00, c[1:0], 4'h9});
            chk("amp level", {6'h0, c[1:0]}, {6'h0, amp});
        end
        chk("vref", 8'h02, {6'h0, vref});
        chk("supply", 8'h00, {7'h0, sup});
        chk("ref src", 8'h01, {7'h0, rsrc});
        apb(1'b0, 8'h00, 8'h00);
        chk("unmapped err", 8'h01, {7'h0, e});
        apb(1'b1, cts_pkg::IDX_CH0_LO, 8'hAA);
        rdchk("ro write", cts_pkg::IDX_CH0_LO, 8'h00);
        // pin drive is registered: look one edge after the write
        apb(1'b1, cts_pkg::IDX_ANALOG, 8'h40);
        @(posedge pclk);
        #1;
        chk("idle low oe", 8'h3F, {2'h0, eoe});
        chk("idle low out", 8'h00, {2'h0, eo});
        apb(1'b1, cts_pkg::IDX_ANALOG, 8'h00);
        @(posedge pclk);
        #1;
        chk("idle float oe", 8'h00, {2'h0, eoe});
        chk("discharge idle", 8'h00, {7'h0, dis});
        $display("test registers done");
        // no start bit in bit mode: nothing may happen
        ch_en <= 5'b00101;
        repeat (400) @(posedge pclk);
        rdchk("idle flags", cts_pkg::IDX_DONE, 8'h00);
        for (int k = 0; k < 3; k++) begin
            scan(sdd[k], sct[k], 8'h05);
            rdchk("ch0 lo", cts_pkg::IDX_CH0_LO, 8'h05);
            rdchk("ch0 hi", cts_pkg::IDX_CH0_HI, 8'h00);
            rdchk("ch2 lo", cts_pkg::IDX_CH2_LO, 8'h05);
            chk("irq set", 8'h01, {7'h0, irq});
            apb(1'b1, cts_pkg::IDX_DONE, 8'h01);
            rdchk("w1c", cts_pkg::IDX_DONE, 8'h04);
            apb(1'b1, cts_pkg::IDX_DONE, 8'h04);
            chk("irq clr", 8'h00, {7'h0, irq});
        end
        $display("test manual scans done");
        apb(1'b1, cts_pkg::IDX_IRQ_ENABLE, 8'h00);
        scan(8'h01, 8'hC0, 8'h05);
        chk("irq masked", 8'h00, {7'h0, irq});
        apb(1'b1, cts_pkg::IDX_IRQ_ENABLE, 8'h01);
        // the interrupt flop sees the new mask one edge later
        @(posedge pclk);
        #1;
        chk("irq unmask", 8'h01, {7'h0, irq});
        rdchk("status", cts_pkg::IDX_IRQ_STATUS, 8'h05);
        apb(1'b1, cts_pkg::IDX_IRQ_CLEAR, 8'h05);
        chk("irq cleared", 8'h00, {7'h0, irq});
        target <= 16'h0009;
        ch_en <= 5'b00001;
        scan(8'h01, 8'h88, 8'h21);
        rdchk("ch0 new", cts_pkg::IDX_CH0_LO, 8'h09);
        rdchk("ch2 kept", cts_pkg::IDX_CH2_LO, 8'h05);
        rdchk("ref lo", cts_pkg::IDX_REF_LO, 8'h09);
        $display("test overwrite done");
        apb(1'b1, cts_pkg::IDX_DONE, 8'h21);
        apb(1'b1, cts_pkg::IDX_CLK_SRC, 8'h01);
        apb(1'b1, cts_pkg::IDX_CONTROL, 8'h28);
        poll(cts_pkg::IDX_DONE, 8'h21, 8'h21);
        rdchk("timer ref", cts_pkg::IDX_REF_LO, 8'h09);
        $display("test timer mode done");
        end_sim;
    end
endmodule
